// >>> logic/lchp_host_port.sv
// Host parallel port of the LCD controller: strobe decode, command and
// parameter sequencing, cursor, glyph fetch addressing, register slave.
// Assumes host pins are asynchronous and display memory answers in one cycle.
//
// How it works
// [R1] Strobe pair: read low, write high, select high reads; write low writes.
// [R2] Enable style: enable high, rw high with select high reads; rw low writes.
// [R3] Data strobe style: strobe low, direction high with select high reads; direction low writes.
// [R4] Straps, caught in reset, choose which of three styles decodes the strobes.
// [R5] Host wires select to its lowest address bit.
// [R6] With internal ROM, codes 80h-9Fh and E0h-FFh come from glyph RAM.
// [R7] External glyph bit set: every code is fetched from glyph RAM.
// [R8] 5Ch then low and high parameter bytes load the glyph base address.
// [R9] Command 4Ch sets cursor shift direction to the right.
// [R10] 46h then low and high parameter bytes set the cursor address.
// [R11] Graphics-only use needs no glyph RAM patterns.
// [R12] Glyph fetch address is base plus shifted code plus row.
// [R13] Tall glyph bit: clear shifts code by three, set shifts by four.
// [R14] After 42h each data write stores at cursor, then cursor moves.
// [R15] A command write ends the previous command's parameter sequence.
`timescale 1ns/100ps
module lchp_host_port (
  input wire logic core_clk,
  input wire logic rst_b,
  input wire logic [2:0] bus_style_straps,
  input wire logic strobe_a_pin,
  input wire logic strobe_b_pin,
  input wire logic cmd_data_select,
  input wire logic [7:0] host_data_in,
  output logic [7:0] host_data_out,
  output logic host_data_oe_n,
  output logic mem_wr_pulse,
  output logic [15:0] mem_addr,
  output logic [7:0] mem_wdata,
  input wire logic [7:0] mem_rdata,
  input wire logic fetch_req,
  input wire logic [7:0] fetch_code,
  input wire logic [3:0] fetch_row,
  output logic fetch_valid,
  output logic [15:0] fetch_addr,
  output logic fetch_from_ram,
  input wire logic [3:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest
);
  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [2:0] style;
    logic [lchp_pkg::PIN_W-1:0] sync1;
    logic [lchp_pkg::PIN_W-1:0] sync2;
    logic [lchp_pkg::PIN_W-1:0] sync3;
    logic [lchp_pkg::PIN_W-1:0] filt;
    lchp_pkg::lchp_op_t op_prev;
    logic [7:0] cmd;
    logic [1:0] pidx;
    logic [15:0] cursor;
    logic [15:0] gbase;
    logic ext_glyph;
    logic dir_left;
    logic tall_glyph;
    logic [7:0] dout;
    logic oe_n;
    logic mem_wr;
    logic [15:0] maddr;
    logic [7:0] mwdata;
    logic fvalid;
    logic [15:0] faddr;
    logic framsel;
    logic [31:0] rdata;
    logic wait_req;
  } lchp_state_t;

  lchp_state_t st_q;
  lchp_state_t st_d;
  lchp_pkg::lchp_op_t op;
  logic sa;
  logic sb;
  logic sel;
  logic [7:0] din;
  logic [15:0] code_off;
  logic in_ram_range;
  logic strobe_a_idle;

  // Synchroniser resets to the strapped idle level; else enable style sees a read at release
  assign strobe_a_idle = (bus_style_straps != lchp_pkg::STYLE_ENABLE); // [R4]

  // ----------------------------------------------------------------
  // Strobe decode per bus style
  // ----------------------------------------------------------------
  always_comb begin
    sa = st_q.filt[lchp_pkg::PIN_STROBE_A];
    sb = st_q.filt[lchp_pkg::PIN_STROBE_B];
    sel = st_q.filt[lchp_pkg::PIN_SELECT];
    din = st_q.filt[7:0];
    op = lchp_pkg::LCHP_OP_NONE;
    if (st_q.style == lchp_pkg::STYLE_ENABLE) begin
      if (sa && sb && sel) begin
        op = lchp_pkg::LCHP_OP_READ; // [R2]
      end else if (sa && !sb) begin
        op = sel ? lchp_pkg::LCHP_OP_CMD_WR : lchp_pkg::LCHP_OP_DATA_WR; // [R2]
      end
    end else if (st_q.style == lchp_pkg::STYLE_DATA_STROBE) begin
      if (!sa && sb && sel) begin
        op = lchp_pkg::LCHP_OP_READ; // [R3]
      end else if (!sa && !sb) begin
        op = sel ? lchp_pkg::LCHP_OP_CMD_WR : lchp_pkg::LCHP_OP_DATA_WR; // [R3]
      end
    end else begin
      if (!sa && sb && sel) begin
        op = lchp_pkg::LCHP_OP_READ; // [R1]
      end else if (sa && !sb) begin
        op = sel ? lchp_pkg::LCHP_OP_CMD_WR : lchp_pkg::LCHP_OP_DATA_WR; // [R1]
      end
    end
  end

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    st_d = st_q;
    // Three stages; a change counts once stages two and three agree
    st_d.sync1 = {cmd_data_select, strobe_b_pin, strobe_a_pin, host_data_in};
    st_d.sync2 = st_q.sync1;
    st_d.sync3 = st_q.sync2;
    st_d.filt = (st_q.sync2 & st_q.sync3) | (st_q.filt & (st_q.sync2 ^ st_q.sync3));
    st_d.op_prev = op;
    st_d.mem_wr = 1'b0;
    st_d.maddr = st_q.cursor;
    st_d.dout = mem_rdata;
    st_d.oe_n = (op != lchp_pkg::LCHP_OP_READ);
    // Act once per strobe, on the cycle the decoded operation first appears
    if (op != st_q.op_prev && op == lchp_pkg::LCHP_OP_CMD_WR) begin
      st_d.cmd = din; // [R15]
      st_d.pidx = 2'h0; // [R15]
      if (din == lchp_pkg::CMD_CURSOR_DIR) begin
        st_d.dir_left = 1'b0; // [R9]
      end
    end else if (op != st_q.op_prev && op == lchp_pkg::LCHP_OP_DATA_WR) begin
      if (st_q.pidx != 2'h2) begin
        st_d.pidx = st_q.pidx + 2'h1;
      end
      case (st_q.cmd)
        lchp_pkg::CMD_GLYPH_BASE_SET: begin
          if (st_q.pidx == 2'h0) begin
            st_d.gbase[7:0] = din; // [R8]
          end else if (st_q.pidx == 2'h1) begin
            st_d.gbase[15:8] = din; // [R8]
          end
        end
        lchp_pkg::CMD_CURSOR_WRITE: begin
          if (st_q.pidx == 2'h0) begin
            st_d.cursor[7:0] = din; // [R10]
          end else if (st_q.pidx == 2'h1) begin
            st_d.cursor[15:8] = din; // [R10]
          end
        end
        lchp_pkg::CMD_MEMORY_WRITE: begin
          st_d.mem_wr = 1'b1; // [R14]
          st_d.maddr = st_q.cursor; // [R14]
          st_d.mwdata = din; // [R14]
          st_d.cursor = st_q.dir_left ? st_q.cursor - 16'h0001 : st_q.cursor + 16'h0001; // [R14]
        end
        default: begin
        end
      endcase
    end
    // Glyph fetch address and source
    code_off = st_q.tall_glyph ? {4'h0, fetch_code, fetch_row} // [R13]
                               : {5'h00, fetch_code, fetch_row[2:0]}; // [R13]
    in_ram_range = (fetch_code >= lchp_pkg::GLYPH_LOW_FIRST && fetch_code <= lchp_pkg::GLYPH_LOW_LAST)
                   || (fetch_code >= lchp_pkg::GLYPH_HIGH_FIRST); // [R6]
    st_d.fvalid = fetch_req;
    if (fetch_req) begin
      st_d.faddr = st_q.gbase + code_off; // [R12]
      st_d.framsel = st_q.ext_glyph || in_ram_range; // [R6] [R7]
    end
    // Register slave: one wait cycle, then a single answer cycle
    st_d.wait_req = 1'b1;
    if ((avs_read || avs_write) && st_q.wait_req) begin
      st_d.wait_req = 1'b0;
      st_d.rdata = 32'h0000_0000;
      if (avs_address == lchp_pkg::ADDR_CTRL) begin
        st_d.rdata[lchp_pkg::CTRL_EXT_GLYPH] = st_q.ext_glyph;
        st_d.rdata[lchp_pkg::CTRL_DIR_LEFT] = st_q.dir_left;
        st_d.rdata[lchp_pkg::CTRL_TALL_GLYPH] = st_q.tall_glyph;
      end else if (avs_address == lchp_pkg::ADDR_CURSOR) begin
        st_d.rdata[15:0] = st_q.cursor;
      end else if (avs_address == lchp_pkg::ADDR_GBASE) begin
        st_d.rdata[15:0] = st_q.gbase;
      end else if (avs_address == lchp_pkg::ADDR_STATUS) begin
        st_d.rdata[2:0] = st_q.style;
        st_d.rdata[lchp_pkg::STATUS_CMD_LSB +: 8] = st_q.cmd;
      end
    end
    if (avs_write && !st_q.wait_req && avs_address == lchp_pkg::ADDR_CTRL) begin
      st_d.ext_glyph = avs_writedata[lchp_pkg::CTRL_EXT_GLYPH]; // [R7]
      st_d.dir_left = avs_writedata[lchp_pkg::CTRL_DIR_LEFT];
      st_d.tall_glyph = avs_writedata[lchp_pkg::CTRL_TALL_GLYPH]; // [R13]
    end
  end

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      st_q <= '0;
      st_q.style <= bus_style_straps; // [R4]
      st_q.filt <= {1'b1, 1'b1, strobe_a_idle, 8'h00};
      st_q.sync1 <= {1'b1, 1'b1, strobe_a_idle, 8'h00};
      st_q.sync2 <= {1'b1, 1'b1, strobe_a_idle, 8'h00};
      st_q.sync3 <= {1'b1, 1'b1, strobe_a_idle, 8'h00};
      st_q.cmd <= lchp_pkg::CMD_RESET_VALUE;
      st_q.cursor <= lchp_pkg::CURSOR_RESET;
      st_q.gbase <= lchp_pkg::GBASE_RESET;
      st_q.oe_n <= 1'b1;
      st_q.wait_req <= 1'b1;
    end else begin
      st_q <= st_d;
    end
  end

  assign host_data_out = st_q.dout;
  assign host_data_oe_n = st_q.oe_n;
  assign mem_wr_pulse = st_q.mem_wr;
  assign mem_addr = st_q.maddr;
  assign mem_wdata = st_q.mwdata;
  assign fetch_valid = st_q.fvalid;
  assign fetch_addr = st_q.faddr;
  assign fetch_from_ram = st_q.framsel;
  assign avs_readdata = st_q.rdata;
  assign avs_waitrequest = st_q.wait_req;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  a_style_held: assert property (@(posedge core_clk) disable iff (!rst_b) // [R4]
    $stable(st_q.style)) else $error("Bus style changed outside reset");
  a_cmd_restart: assert property (@(posedge core_clk) disable iff (!rst_b) // [R15]
    (op == lchp_pkg::LCHP_OP_CMD_WR && st_q.op_prev != op) |=> (st_q.pidx == 2'h0))
    else $error("Command write did not restart parameters");
  a_dir_right: assert property (@(posedge core_clk) disable iff (!rst_b) // [R9]
    (op == lchp_pkg::LCHP_OP_CMD_WR && st_q.op_prev != op && din == lchp_pkg::CMD_CURSOR_DIR)
    |=> !st_q.dir_left) else $error("Direction command did not select right");
  a_cursor_low: assert property (@(posedge core_clk) disable iff (!rst_b) // [R10]
    (op == lchp_pkg::LCHP_OP_DATA_WR && st_q.op_prev != op && st_q.pidx == 2'h0
     && st_q.cmd == lchp_pkg::CMD_CURSOR_WRITE) |=> (st_q.cursor[7:0] == $past(din)))
    else $error("Cursor low byte not loaded");
  a_base_high: assert property (@(posedge core_clk) disable iff (!rst_b) // [R8]
    (op == lchp_pkg::LCHP_OP_DATA_WR && st_q.op_prev != op && st_q.pidx == 2'h1
     && st_q.cmd == lchp_pkg::CMD_GLYPH_BASE_SET) |=> (st_q.gbase[15:8] == $past(din)))
    else $error("Glyph base high byte not loaded");
  a_memory_write_cmd_advance: assert property (@(posedge core_clk) disable iff (!rst_b) // [R14]
    mem_wr_pulse |-> (mem_addr == (st_q.dir_left ? st_q.cursor + 16'h0001
                                                 : st_q.cursor - 16'h0001)))
    else $error("Cursor did not move after memory write");
  a_fetch_source: assert property (@(posedge core_clk) disable iff (!rst_b) // [R6]
    (fetch_req && !st_q.ext_glyph && fetch_code < lchp_pkg::GLYPH_LOW_FIRST)
    |=> (fetch_valid && !fetch_from_ram)) else $error("Low code fetched from glyph RAM");
  a_fetch_ext: assert property (@(posedge core_clk) disable iff (!rst_b) // [R7]
    (fetch_req && st_q.ext_glyph) |=> fetch_from_ram)
    else $error("External glyph source ignored");
  a_fetch_addr: assert property (@(posedge core_clk) disable iff (!rst_b) // [R12]
    (fetch_req && !st_q.tall_glyph) |=> (fetch_addr == $past(st_q.gbase)
      + {5'h00, $past(fetch_code), $past(fetch_row[2:0])}))
    else $error("Short glyph fetch address wrong");
  a_read_drive: assert property (@(posedge core_clk) disable iff (!rst_b) // [R1]
    (op == lchp_pkg::LCHP_OP_READ) |=> !host_data_oe_n)
    else $error("Read did not drive data bus");
  a_bus_answer: assert property (@(posedge core_clk) disable iff (!rst_b)
    ((avs_read || avs_write) && avs_waitrequest) |=> !avs_waitrequest)
    else $error("Register access not answered in one cycle");
endmodule

// >>> logic/lchp_pkg.sv
// Constants, encodings and register map of the LCD host command port.
// Assumes a single 25 MHz core clock and an Avalon-MM register slave.
package lchp_pkg;
  // ----------------------------------------------------------------
  // Bus styles selected by straps
  // ----------------------------------------------------------------
  localparam logic [2:0] STYLE_STROBE_PAIR = 3'h0;
  localparam logic [2:0] STYLE_ENABLE = 3'h1;
  localparam logic [2:0] STYLE_DATA_STROBE = 3'h2;
  // ----------------------------------------------------------------
  // Command codes
  // ----------------------------------------------------------------
  localparam logic [7:0] CMD_GLYPH_BASE_SET = 8'h5C;
  localparam logic [7:0] CMD_CURSOR_DIR = 8'h4C;
  localparam logic [7:0] CMD_CURSOR_WRITE = 8'h46;
  localparam logic [7:0] CMD_MEMORY_WRITE = 8'h42;
  localparam logic [7:0] CMD_RESET_VALUE = 8'h00;
  // ----------------------------------------------------------------
  // Glyph source ranges held in glyph RAM
  // ----------------------------------------------------------------
  localparam logic [7:0] GLYPH_LOW_FIRST = 8'h80;
  localparam logic [7:0] GLYPH_LOW_LAST = 8'h9F;
  localparam logic [7:0] GLYPH_HIGH_FIRST = 8'hE0;
  // ----------------------------------------------------------------
  // Register map (byte addresses) and fields
  // ----------------------------------------------------------------
  localparam logic [3:0] ADDR_CTRL = 4'h0;
  localparam logic [3:0] ADDR_CURSOR = 4'h4;
  localparam logic [3:0] ADDR_GBASE = 4'h8;
  localparam logic [3:0] ADDR_STATUS = 4'hC;
  localparam int CTRL_EXT_GLYPH = 0;
  localparam int CTRL_DIR_LEFT = 1;
  localparam int CTRL_TALL_GLYPH = 2;
  localparam int STATUS_CMD_LSB = 8;
  localparam logic [15:0] CURSOR_RESET = 16'h0000;
  localparam logic [15:0] GBASE_RESET = 16'h0000;
  // ----------------------------------------------------------------
  // Host pin vector layout after synchronising
  // ----------------------------------------------------------------
  localparam int PIN_W = 11;
  localparam int PIN_STROBE_A = 8;
  localparam int PIN_STROBE_B = 9;
  localparam int PIN_SELECT = 10;
  typedef enum logic [1:0] {LCHP_OP_NONE, LCHP_OP_READ, LCHP_OP_DATA_WR, LCHP_OP_CMD_WR} lchp_op_t;
endpackage

// >>> sim/lchp_host_sim.sv
// Host processor model that drives the parallel port pins.
// Assumes one caller of op() at a time and style held fixed between resets.
`timescale 1ns/100ps
module lchp_host_sim (
  input wire logic core_clk,
  input wire logic [2:0] style,
  output logic strobe_a_pin,
  output logic strobe_b_pin,
  output logic cmd_data_select,
  output logic [7:0] host_data_in
);
  logic busy = 1'b0;
  initial begin
    strobe_a_pin = 1'b1;
    strobe_b_pin = 1'b1;
    cmd_data_select = 1'b1;
    host_data_in = 8'h00;
  end
  // Idle strobes follow the strapped style, so a restrap never leaves a live strobe
  always @(posedge core_clk) if (!busy) strobe_a_pin <= (style != 3'h1);
  // Kind 0 read, 1 data or parameter write, 2 command write
  task automatic op(input logic [1:0] kind, input logic [7:0] d);
    @(posedge core_clk);
    busy <= 1'b1;
    cmd_data_select <= (kind != 2'h1);
    host_data_in <= d;
    // Data settles before the strobe, since it passes the same synchroniser
    repeat (4) @(posedge core_clk);
    strobe_a_pin <= (style == 3'h1) || (style == 3'h0 && kind != 2'h0);
    strobe_b_pin <= (kind == 2'h0);
    repeat (6) @(posedge core_clk);
    strobe_a_pin <= (style != 3'h1);
    strobe_b_pin <= 1'b1;
    host_data_in <= ~d;
    repeat (6) @(posedge core_clk);
    busy <= 1'b0;
  endtask
endmodule

// >>> sim/testbench.sv
// Self-checking bench for the LCD host command port.
// Assumes the host model drives the pins and the bench owns every other input.
`timescale 1ns/100ps
module testbench;
  logic core_clk = 1'b0;
  logic rst_b = 1'b0;
  logic [2:0] bus_style_straps = 3'h0;
  logic strobe_a_pin, strobe_b_pin, cmd_data_select, host_data_oe_n, mem_wr_pulse;
  logic [7:0] host_data_in, host_data_out, mem_wdata, fetch_code;
  logic [7:0] mem_rdata = 8'h00;
  logic [15:0] mem_addr, fetch_addr;
  logic fetch_req = 1'b0;
  logic [3:0] fetch_row = 4'h0;
  logic fetch_valid, fetch_from_ram, avs_waitrequest, oe_q = 1'b1;
  logic [3:0] avs_address = 4'h0;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0;
  logic [31:0] avs_readdata;
  logic [31:0] mq[$], fq[$], rq[$], hq[$];
  logic [7:0] edges [8] = '{8'h00, 8'h7F, 8'h80, 8'h9F, 8'hA0, 8'hDF, 8'hE0, 8'hFF};
  int seed = 32'h6c6ec1f0;
  int bad_count = 0;
  int n_checks = 0;
  initial fetch_code = 8'h00;
  initial forever #20 core_clk = ~core_clk;
  lchp_host_port lchp_host_port_inst (.core_clk(core_clk), .rst_b(rst_b),
    .bus_style_straps(bus_style_straps), .strobe_a_pin(strobe_a_pin),
    .strobe_b_pin(strobe_b_pin), .cmd_data_select(cmd_data_select),
    .host_data_in(host_data_in), .host_data_out(host_data_out),
    .host_data_oe_n(host_data_oe_n), .mem_wr_pulse(mem_wr_pulse), .mem_addr(mem_addr),
    .mem_wdata(mem_wdata), .mem_rdata(mem_rdata), .fetch_req(fetch_req),
    .fetch_code(fetch_code), .fetch_row(fetch_row), .fetch_valid(fetch_valid),
    .fetch_addr(fetch_addr), .fetch_from_ram(fetch_from_ram), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest));
  lchp_host_sim host_sim_inst (.core_clk(core_clk), .style(bus_style_straps),
    .strobe_a_pin(strobe_a_pin), .strobe_b_pin(strobe_b_pin),
    .cmd_data_select(cmd_data_select), .host_data_in(host_data_in));
  // ----------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------
  task automatic cmp(input logic [31:0] e, input logic [31:0] a, input string what);
    n_checks++;
    if (a !== e) begin
      bad_count++;
      $display("BAD %0t %s: expected %h got %h", $time, what, e, a);
    end
  endtask
  function automatic logic [31:0] pop(ref logic [31:0] q[$]);
    return q.size() ? q.pop_front() : 'x;
  endfunction
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic do_reset(input logic [2:0] s);
    bus_style_straps <= s;
    rst_b <= 1'b0;
    repeat (10) @(posedge core_clk);
    rst_b <= 1'b1;
    repeat (4) @(posedge core_clk);
  endtask
  // Held until the edge that samples waitrequest low
  task automatic acc(input logic [3:0] a, input logic w, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge core_clk);
    avs_address <= a;
    avs_read <= !w;
    avs_write <= w;
    avs_writedata <= d;
    do begin
      @(posedge core_clk);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 50);
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    if (n >= 50) cmp(32'h0, 32'h1, "bus wait");
  endtask
  task automatic rd(input logic [3:0] a, input logic [31:0] e);
    rq.push_back(e);
    acc(a, 1'b0, 32'h0);
  endtask
  task automatic fetch(input logic [7:0] c, input logic [3:0] r, input logic t, input logic e);
    logic [15:0] a;
    a = t ? {4'h0, c, r} : {5'h0, c, r[2:0]};
    fq.push_back({15'h0, e | (c >= 8'h80 && c <= 8'h9F) | (c >= 8'hE0), 16'h4000 + a});
    @(posedge core_clk);
    fetch_req <= 1'b1;
    fetch_code <= c;
    fetch_row <= r;
  endtask
  // Results are judged at the falling edge, where registered outputs have settled
  always @(negedge core_clk) begin
    if (rst_b && mem_wr_pulse === 1'b1) cmp(pop(mq), {8'h0, mem_addr, mem_wdata}, "mem");
    if (rst_b && fetch_valid === 1'b1) cmp(pop(fq), {15'h0, fetch_from_ram, fetch_addr}, "fetch");
    if (avs_read && avs_waitrequest === 1'b0) cmp(pop(rq), avs_readdata, "reg");
    if (rst_b && host_data_oe_n === 1'b0 && oe_q) cmp(pop(hq), {24'h0, host_data_out}, "pin");
    oe_q <= (host_data_oe_n !== 1'b0);
  end
  initial begin
    #(40 * 20000);
    cmp(32'h0, 32'h1, "watchdog");
    print_verdict();
  end
  initial begin
    logic [7:0] b;
    // Style runs are graphics-only: no glyph patterns are loaded first
    for (int s = 0; s < 3; s++) begin
      do_reset(s[2:0]);
      mem_rdata <= 8'($random(seed));
      rd(lchp_pkg::ADDR_STATUS, {29'h0, s[2:0]});
      host_sim_inst.op(2'h2, lchp_pkg::CMD_CURSOR_WRITE);
      host_sim_inst.op(2'h1, 8'h00);
      host_sim_inst.op(2'h1, 8'h48);
      host_sim_inst.op(2'h2, lchp_pkg::CMD_MEMORY_WRITE);
      for (int i = 0; i < 2; i++) begin
        b = 8'($random(seed));
        mq.push_back({8'h0, 16'h4800 + i[15:0], b});
        host_sim_inst.op(2'h1, b);
      end
      rd(lchp_pkg::ADDR_CURSOR, 32'h4802);
      hq.push_back({24'h0, mem_rdata});
      host_sim_inst.op(2'h0, 8'h00);
      rd(lchp_pkg::ADDR_STATUS, {16'h0, lchp_pkg::CMD_MEMORY_WRITE, 5'h0, s[2:0]});
      $display("test style %0d done", s);
    end
    host_sim_inst.op(2'h2, lchp_pkg::CMD_GLYPH_BASE_SET);
    host_sim_inst.op(2'h1, 8'h00);
    host_sim_inst.op(2'h1, 8'h40);
    host_sim_inst.op(2'h1, 8'h77);
    rd(lchp_pkg::ADDR_GBASE, 32'h4000);
    acc(lchp_pkg::ADDR_GBASE, 1'b1, 32'h1234);
    rd(lchp_pkg::ADDR_GBASE, 32'h4000);
    rd(4'h2, 32'h0);
    host_sim_inst.op(2'h2, lchp_pkg::CMD_CURSOR_WRITE);
    host_sim_inst.op(2'h1, 8'h10);
    host_sim_inst.op(2'h1, 8'h00);
    acc(lchp_pkg::ADDR_CTRL, 1'b1, 32'h2);
    rd(lchp_pkg::ADDR_CTRL, 32'h2);
    host_sim_inst.op(2'h2, lchp_pkg::CMD_MEMORY_WRITE);
    mq.push_back(32'h00105A);
    host_sim_inst.op(2'h1, 8'h5A);
    host_sim_inst.op(2'h2, lchp_pkg::CMD_CURSOR_DIR);
    host_sim_inst.op(2'h2, lchp_pkg::CMD_MEMORY_WRITE);
    mq.push_back(32'h000FA5);
    host_sim_inst.op(2'h1, 8'hA5);
    rd(lchp_pkg::ADDR_CURSOR, 32'h0010);
    $display("test commands done");
    for (int m = 0; m < 4; m++) begin
      acc(lchp_pkg::ADDR_CTRL, 1'b1, {29'h0, m[1], 1'b0, m[0]});
      for (int k = 0; k < 24; k++) begin
        fetch(k < 8 ? edges[k] : 8'($random(seed)), 4'($random(seed)), m[1], m[0]);
      end
      @(posedge core_clk);
      fetch_req <= 1'b0;
    end
    $display("test fetch done");
    repeat (4) @(posedge core_clk);
    cmp(32'(mq.size() + fq.size() + rq.size() + hq.size()), 32'h0, "leftover");
    print_verdict();
  end
endmodule
